// >>> rtl/pio_pin_cell.sv
// one port pin: output driver and input conditioning
module pio_pin_cell (
  input  wire logic latch,      // output latch value
  input  wire logic push_pull,  // 1: push-pull, 0: open drain
  input  wire logic force_od,   // two-wire bus pin override
  input  wire logic digital,    // 1: digital input, 0: analog
  input  wire logic pin_in,     // pin level
  output wire logic drv_out,    // level driven on pin
  output wire logic drv_oe,     // high while driving
  output wire logic level       // digital read value
);
  wire eff_pp = push_pull & ~force_od;
  // open drain only pulls low; high is released to the pullup
  assign drv_out = latch;
  assign drv_oe  = eff_pp | ~latch;
  // analog cells read as zero so the buffer can be powered down
  assign level   = digital & pin_in;
endmodule : pio_pin_cell

// >>> rtl/pio_pkg.sv
package pio_pkg;
  // register addresses in the special function space
  localparam logic [7:0] PIO_ADDR_PORT0_DATA = 8'h80; // all pages
  localparam logic [7:0] PIO_ADDR_PORT1_DATA = 8'h90; // all pages
  localparam logic [7:0] PIO_ADDR_PORT4_DATA = 8'h98; // all pages, byte only
  localparam logic [7:0] PIO_ADDR_P0_SKIP    = 8'hd4; // page below
  localparam logic [7:0] PIO_ADDR_P0_INMODE  = 8'hf1; // page below
  localparam logic [7:0] PIO_ADDR_P1_INMODE  = 8'hf2; // page below
  localparam logic [7:0] PIO_ADDR_P0_OUTMODE = 8'ha4; // page below
  localparam logic [7:0] PIO_ADDR_P1_OUTMODE = 8'ha5; // page below
  localparam logic [7:0] PIO_ADDR_P4_OUTMODE = 8'hae; // page below
  localparam logic [7:0] PIO_CFG_PAGE        = 8'h0f; // configuration page
  // reset values
  localparam logic [7:0] PIO_RST_DATA        = 8'hff;
  localparam logic [7:0] PIO_RST_SKIP        = 8'h00;
  localparam logic [7:0] PIO_RST_INMODE      = 8'hff; // digital
  localparam logic [7:0] PIO_RST_OUTMODE     = 8'h00; // open drain
  // two-wire bus pin positions on port 0
  localparam int PIO_SDA_BIT = 0;
  localparam int PIO_SCL_BIT = 1;
  // access kinds from the core
  typedef enum logic [1:0] {
    PIO_ACC_BYTE,   // whole byte
    PIO_ACC_BIT     // single bit
  } pio_acc_t;
endpackage : pio_pkg

// >>> rtl/pio_port_io.sv
// What this block does
// - write stores byte in output latch
// - plain read returns live levels of digital pins, zero for analog pins
// - read-modify-write reads latch, not pins
// - byte and bit access on ports 0 and 1, port 4 and config registers byte-only
// - skip bit one makes crossbar pass pin
// - per-pin analog/digital input selection on ports 0 and 1
// - per-pin open-drain/push-pull output selection
// - two-wire bus pins forced open drain while smbus_en is set
// - port 0 data at 0x80, resets ones
// - port 1 data at 0x90, resets ones
// - port 0 skip at 0xd4 page 0x0f
// - write zero drives low, read reports level
module pio_port_io
  import pio_pkg::*;
(
  input  wire logic        mclk,          // system clock
  input  wire logic        rstn,          // sync reset, active low
  input  wire logic [7:0]  sfr_addr,      // register address
  input  wire logic [7:0]  sfr_page,      // current register page
  input  wire logic        sfr_wr,        // write strobe
  input  wire logic        sfr_rd,        // read strobe
  input  wire logic        sfr_bit,       // bit access
  input  wire logic [2:0]  sfr_bitsel,    // bit number
  input  wire logic        sfr_rmw,       // read-modify-write read
  input  wire logic [7:0]  sfr_wdata,     // write byte, bit in [0]
  output logic      [7:0]  sfr_rdata,     // read byte
  input  wire logic [7:0]  p0_pin_in,     // port 0 pin levels
  input  wire logic [7:0]  p1_pin_in,     // port 1 pin levels
  input  wire logic [7:0]  p4_pin_in,     // port 4 pin levels
  input  wire logic        smbus_en,      // two-wire bus routed to pins
  output logic      [7:0]  p0_pin_out,    // port 0 drive level
  output logic      [7:0]  p0_pin_oe,     // port 0 drive enable
  output logic      [7:0]  p1_pin_out,    // port 1 drive level
  output logic      [7:0]  p1_pin_oe,     // port 1 drive enable
  output logic      [7:0]  p4_pin_out,    // port 4 drive level
  output logic      [7:0]  p4_pin_oe,     // port 4 drive enable
  output logic      [7:0]  p0_skip        // to crossbar decoder
);
  // storage
  logic [7:0] port0_data_r, port1_data_r, port4_data_r;   // output latches
  logic [7:0] p0_skip_r;                                  // crossbar skip
  logic [7:0] p0_inmode_r, p1_inmode_r;                   // 1: digital
  logic [7:0] p0_outmode_r, p1_outmode_r, p4_outmode_r;   // 1: push-pull
  logic [7:0] rdata_r;                                    // read holding

  // decode; data ports seen on every page, config only on its page
  wire cfg_pg  = (sfr_page == PIO_CFG_PAGE);
  wire hit_p0  = (sfr_addr == PIO_ADDR_PORT0_DATA);
  wire hit_p1  = (sfr_addr == PIO_ADDR_PORT1_DATA);
  wire hit_p4  = (sfr_addr == PIO_ADDR_PORT4_DATA) & ~sfr_bit;
  wire hit_sk  = cfg_pg & (sfr_addr == PIO_ADDR_P0_SKIP) & ~sfr_bit;
  wire hit_i0  = cfg_pg & (sfr_addr == PIO_ADDR_P0_INMODE) & ~sfr_bit;
  wire hit_i1  = cfg_pg & (sfr_addr == PIO_ADDR_P1_INMODE) & ~sfr_bit;
  wire hit_o0  = cfg_pg & (sfr_addr == PIO_ADDR_P0_OUTMODE) & ~sfr_bit;
  wire hit_o1  = cfg_pg & (sfr_addr == PIO_ADDR_P1_OUTMODE) & ~sfr_bit;
  wire hit_o4  = cfg_pg & (sfr_addr == PIO_ADDR_P4_OUTMODE) & ~sfr_bit;

  // bit-write mask: only the addressed bit changes
  wire [7:0] bmask = 8'h01 << sfr_bitsel;
  wire [7:0] bval  = {8{sfr_wdata[0]}};
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] m,
                                       input logic [7:0] v,
                                       input logic       b);
    merge = b ? ((old & ~m) | (v & m)) : v;
  endfunction : merge

  // next latch values; a bit write keeps the other seven latch bits
  wire [7:0] p0_wv  = sfr_bit ? merge(port0_data_r, bmask, bval, 1'b1)
                              : sfr_wdata;
  wire [7:0] p1_wv  = sfr_bit ? merge(port1_data_r, bmask, bval, 1'b1)
                              : sfr_wdata;

  // two-wire bus override on the bus pins
  wire [7:0] p0_force = smbus_en ?
    ((8'h01 << PIO_SDA_BIT) | (8'h01 << PIO_SCL_BIT)) : 8'h00;

  // pin cells
  wire [7:0] p0_lvl, p1_lvl, p4_lvl;
  wire [7:0] p0_do, p0_de, p1_do, p1_de, p4_do, p4_de;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      pio_pin_cell u_p0 (
        .latch     (port0_data_r[g]),
        .push_pull (p0_outmode_r[g]),
        .force_od  (p0_force[g]),
        .digital   (p0_inmode_r[g]),
        .pin_in    (p0_pin_in[g]),
        .drv_out   (p0_do[g]),
        .drv_oe    (p0_de[g]),
        .level     (p0_lvl[g])
      );
      pio_pin_cell u_p1 (
        .latch     (port1_data_r[g]),
        .push_pull (p1_outmode_r[g]),
        .force_od  (1'b0),
        .digital   (p1_inmode_r[g]),
        .pin_in    (p1_pin_in[g]),
        .drv_out   (p1_do[g]),
        .drv_oe    (p1_de[g]),
        .level     (p1_lvl[g])
      );
      // port 4 is digital only, so its input select is fixed
      pio_pin_cell u_p4 (
        .latch     (port4_data_r[g]),
        .push_pull (p4_outmode_r[g]),
        .force_od  (1'b0),
        .digital   (1'b1),
        .pin_in    (p4_pin_in[g]),
        .drv_out   (p4_do[g]),
        .drv_oe    (p4_de[g]),
        .level     (p4_lvl[g])
      );
    end
  endgenerate

  // read mux: latch for read-modify-write, pins otherwise
  wire [7:0] p0_rd = sfr_rmw ? port0_data_r : p0_lvl;
  wire [7:0] p1_rd = sfr_rmw ? port1_data_r : p1_lvl;
  wire [7:0] p4_rd = sfr_rmw ? port4_data_r : p4_lvl;
  wire [7:0] rd_byte =
    hit_p0 ? p0_rd : hit_p1 ? p1_rd : hit_p4 ? p4_rd :
    hit_sk ? p0_skip_r : hit_i0 ? p0_inmode_r : hit_i1 ? p1_inmode_r :
    hit_o0 ? p0_outmode_r : hit_o1 ? p1_outmode_r :
    hit_o4 ? p4_outmode_r : 8'h00;
  // a bit read returns the addressed bit in position 0
  wire [7:0] rd_val = sfr_bit ? {7'h00, rd_byte[sfr_bitsel]} : rd_byte;

  // port data latches, reset high
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      port0_data_r <= PIO_RST_DATA;
      port1_data_r <= PIO_RST_DATA;
      port4_data_r <= PIO_RST_DATA;
    end else if (sfr_wr) begin
      if (hit_p0) port0_data_r <= p0_wv;
      if (hit_p1) port1_data_r <= p1_wv;
      if (hit_p4) port4_data_r <= sfr_wdata;
    end
  end

  // configuration registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      p0_skip_r    <= PIO_RST_SKIP;
      p0_inmode_r  <= PIO_RST_INMODE;
      p1_inmode_r  <= PIO_RST_INMODE;
      p0_outmode_r <= PIO_RST_OUTMODE;
      p1_outmode_r <= PIO_RST_OUTMODE;
      p4_outmode_r <= PIO_RST_OUTMODE;
    end else if (sfr_wr) begin
      if (hit_sk) p0_skip_r    <= sfr_wdata;
      if (hit_i0) p0_inmode_r  <= sfr_wdata;
      if (hit_i1) p1_inmode_r  <= sfr_wdata;
      if (hit_o0) p0_outmode_r <= sfr_wdata;
      if (hit_o1) p1_outmode_r <= sfr_wdata;
      if (hit_o4) p4_outmode_r <= sfr_wdata;
    end
  end

  // registered read data and pin drive; one cycle latency
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_r    <= 8'h00;
      p0_pin_out <= 8'hff;
      p0_pin_oe  <= 8'h00;
      p1_pin_out <= 8'hff;
      p1_pin_oe  <= 8'h00;
      p4_pin_out <= 8'hff;
      p4_pin_oe  <= 8'h00;
      p0_skip    <= PIO_RST_SKIP;
    end else begin
      if (sfr_rd) rdata_r <= rd_val;
      p0_pin_out <= p0_do;
      p0_pin_oe  <= p0_de;
      p1_pin_out <= p1_do;
      p1_pin_oe  <= p1_de;
      p4_pin_out <= p4_do;
      p4_pin_oe  <= p4_de;
      p0_skip    <= p0_skip_r;
    end
  end
  assign sfr_rdata = rdata_r;
endmodule : pio_port_io

// >>> testbench/pio_pin_model.sv
// board side of one port: pull-ups plus an optional outside driver
module pio_pin_model (
  input  wire logic [7:0] drv_out, // level from the block
  input  wire logic [7:0] drv_oe,  // block drives where high
  input  wire logic       ext_en,  // outside driver active
  input  wire logic [7:0] ext_val, // outside driver level
  output wire logic [7:0] pin      // resolved wire level
);
  timeunit 1ns;
  timeprecision 100ps;
  // undriven lines take the outside driver level or the pull-up, never a stale value
  assign pin = (drv_oe & drv_out)
             | (~drv_oe & (ext_en ? ext_val : 8'hff));
endmodule : pio_pin_model

// >>> testbench/pio_port_io_chk.sv
// watches the port block at its pins and register strobes
module pio_port_io_chk (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic       sfr_bit,
  input wire logic [2:0] sfr_bitsel,
  input wire logic       sfr_rmw,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [7:0] p0_pin_in,
  input wire logic       smbus_en,
  input wire logic [7:0] p0_pin_out,
  input wire logic [7:0] p0_pin_oe,
  input wire logic [7:0] p1_pin_out,
  input wire logic [7:0] p4_pin_out,
  input wire logic [7:0] p0_skip
);
  timeunit 1ns;
  timeprecision 100ps;
  wire wr_b = sfr_wr && !sfr_bit; // byte write
  wire rd_b = sfr_rd && !sfr_bit; // byte read
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  rst_values_a: assert property ($rose(rstn) |->
    p0_pin_out == 8'hff && p0_pin_oe == 8'h00 && p0_skip == 8'h00)
    else $error("reset values");
  latch_pin_a: assert property (wr_b && sfr_addr == 8'h80 |-> ##2
    p0_pin_out == $past(sfr_wdata, 2)) else $error("latch not on pins");
  bit_write_a: assert property (sfr_wr && sfr_bit
    && sfr_addr == 8'h90
    |-> ##2 p1_pin_out[$past(sfr_bitsel, 2)] == $past(sfr_wdata[0], 2))
    else $error("bit write lost");
  byte_only_a: assert property (sfr_wr && sfr_bit && sfr_addr == 8'h98
    && !$past(sfr_wr) |=> $stable(p4_pin_out) [*2]) else $error("port4 bit");
  pin_read_a: assert property (rd_b && !sfr_rmw && sfr_addr == 8'h80
    |=> sfr_rdata == $past(p0_pin_in)) else $error("pin read wrong");
  rmw_latch_a: assert property (rd_b && sfr_rmw && sfr_addr == 8'h80
    && !sfr_wr && !$past(sfr_wr) |=> sfr_rdata == p0_pin_out)
    else $error("rmw read not latch");
  skip_copy_a: assert property (wr_b && sfr_addr == 8'hd4
    && sfr_page == 8'h0f |-> ##2 p0_skip == $past(sfr_wdata, 2))
    else $error("skip not updated");
  smbus_od_a: assert property (smbus_en && $past(smbus_en)
    && $past(smbus_en, 2) |-> (p0_pin_oe[1:0] & p0_pin_out[1:0]) == 2'b00)
    else $error("bus pin drives high");
  off_page_a: assert property (rd_b && sfr_addr == 8'hd4
    && sfr_page != 8'h0f |=> sfr_rdata == 8'h00) else $error("off page read");
endmodule : pio_port_io_chk
bind pio_port_io pio_port_io_chk pio_port_io_chk_inst (.*);

// >>> testbench/pio_port_io_tb_top.sv
module pio_port_io_tb_top import pio_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk, rstn, sfr_wr, sfr_rd, sfr_bit, sfr_rmw, smbus_en, ext_en;
  logic [2:0] sfr_bitsel;
  logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata, ext_val, rd_v;
  logic [7:0] p0_pin_in, p1_pin_in, p4_pin_in, p0_pin_out, p0_pin_oe;
  logic [7:0] p1_pin_out, p1_pin_oe, p4_pin_out, p4_pin_oe, p0_skip;
  int         error_cnt = 0, n_checks = 0;
  pio_port_io pio_port_io_inst (.*);
  pio_pin_model pio_pin_model_inst0 (.drv_out(p0_pin_out), .drv_oe(p0_pin_oe),
    .ext_en(ext_en), .ext_val(ext_val), .pin(p0_pin_in));
  pio_pin_model pio_pin_model_inst1 (.drv_out(p1_pin_out), .drv_oe(p1_pin_oe),
    .ext_en(1'b0), .ext_val(8'h00), .pin(p1_pin_in));
  pio_pin_model pio_pin_model_inst4 (.drv_out(p4_pin_out), .drv_oe(p4_pin_oe),
    .ext_en(1'b0), .ext_val(8'h00), .pin(p4_pin_in));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one strobe pulse; read data kept in rd_v, one spare edge for pins
  task automatic acc(input logic w, b, m, input logic [2:0] bs,
                     input logic [7:0] a, pg, d);
    @(posedge mclk); #1;
    {sfr_wr, sfr_rd, sfr_bit, sfr_rmw, sfr_bitsel} = {w, !w, b, m, bs};
    {sfr_addr, sfr_page, sfr_wdata} = {a, pg, d};
    @(posedge mclk); #1;
    {sfr_wr, sfr_rd} = 2'b00;
    rd_v = sfr_rdata;
    @(posedge mclk); #1;
  endtask : acc
  task automatic t_reset;
    chk(p0_skip, 8'h00);
    acc(0, 0, 1, 0, PIO_ADDR_PORT0_DATA, 8'h00, 8'h00);
    chk(rd_v, 8'hff);
    acc(0, 0, 1, 0, PIO_ADDR_PORT1_DATA, 8'h0f, 8'h00);
    chk(rd_v, 8'hff);
    acc(0, 0, 0, 0, PIO_ADDR_P0_SKIP, PIO_CFG_PAGE, 8'h00);
    chk(rd_v, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_data;
    ext_en = 1'b1; // outside world pulls released pins to 5a
    acc(1, 0, 0, 0, 8'h80, 8'h00, 8'h0f); chk(p0_pin_out, 8'h0f);
    chk(p0_pin_oe, 8'hf0);
    acc(0, 0, 0, 0, 8'h80, 8'h00, 8'h00); chk(rd_v, 8'h0a);
    acc(0, 0, 1, 0, 8'h80, 8'h00, 8'h00); chk(rd_v, 8'h0f);
    ext_en = 1'b0;
    $display("data test done");
  endtask : t_data
  task automatic t_bits;
    acc(1, 1, 0, 3, 8'h90, 8'h00, 8'h00); chk(p1_pin_out, 8'hf7);
    acc(0, 1, 0, 3, 8'h90, 8'h00, 8'h00); chk({7'h00, rd_v[0]}, 8'h00);
    acc(1, 1, 0, 3, 8'h98, 8'h00, 8'h00); chk(p4_pin_out, 8'hff);
    acc(1, 0, 0, 0, 8'h98, 8'h00, 8'h3c); chk(p4_pin_out, 8'h3c);
    chk(p4_pin_oe, 8'hc3);
    $display("bit test done");
  endtask : t_bits
  task automatic t_modes;
    acc(1, 0, 0, 0, PIO_ADDR_P1_OUTMODE, PIO_CFG_PAGE, 8'hff);
    chk(p1_pin_oe, 8'hff);
    acc(1, 0, 0, 0, PIO_ADDR_P1_OUTMODE, 8'h00, 8'h00);
    chk(p1_pin_oe, 8'hff);
    acc(1, 0, 0, 0, PIO_ADDR_P1_INMODE, PIO_CFG_PAGE, 8'h00);
    acc(0, 0, 0, 0, 8'h90, 8'h00, 8'h00); chk(rd_v, 8'h00);
    acc(1, 0, 0, 0, PIO_ADDR_P1_INMODE, PIO_CFG_PAGE, 8'hff);
    acc(0, 0, 0, 0, 8'h90, 8'h00, 8'h00); chk(rd_v, 8'hf7);
    $display("mode test done");
  endtask : t_modes
  task automatic t_skip_bus;
    acc(1, 0, 0, 0, 8'hd4, 8'h0f, 8'h3c); chk(p0_skip, 8'h3c);
    acc(0, 0, 0, 0, 8'hd4, 8'h00, 8'h00); chk(rd_v, 8'h00);
    acc(1, 0, 0, 0, PIO_ADDR_P0_OUTMODE, PIO_CFG_PAGE, 8'hff);
    smbus_en = 1'b1; // bus pins must stay open drain despite push-pull
    acc(1, 0, 0, 0, 8'h80, 8'h00, 8'hff); chk(p0_pin_oe, 8'hfc);
    $display("skip and bus test done");
  endtask : t_skip_bus
  initial begin
    {rstn, sfr_wr, sfr_rd, sfr_bit, sfr_rmw, smbus_en, ext_en} = 7'h00;
    {sfr_bitsel, sfr_addr, sfr_page, sfr_wdata, ext_val} = {3'h0, 24'h0, 8'h5a};
    repeat (5) @(posedge mclk);
    #1 rstn = 1'b1;
    t_reset;
    t_data;
    t_bits;
    t_modes;
    t_skip_bus;
    tally_and_finish;
  end
  // run should finish in about 1.3 us
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish;
  end
endmodule : pio_port_io_tb_top
